// File: cdpc_pkg.sv
// constants, register map and types of the descriptor master port block
package cdpc_pkg;
   // =====================================================
   // widths
   localparam int REG_ADDR_BITS = 32;
   localparam int REG_WORD_BITS = 32;
   localparam int DESC_PORT_ADDR_BITS = 32;
   localparam int DESC_PORT_WORD_BITS = 32;
   localparam int DESC_WORDS = 8;
   // =====================================================
   // descriptor port fixed codes
   localparam logic [2:0] SIZE_4BYTE = 3'h2;
   localparam logic [1:0] BURST_INCR = 2'h1;
   localparam logic [2:0] PROT_VALUE = 3'h0;
   localparam logic [3:0] CACHE_VALUE = 4'h3;
   localparam logic [3:0] STRB_ALL = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_EXOKAY = 2'h1;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // =====================================================
   // register byte offsets
   localparam logic [REG_ADDR_BITS-1:0] OFS_CTRL = 32'h0000_0000;
   localparam logic [REG_ADDR_BITS-1:0] OFS_ADDR = 32'h0000_0004;
   localparam logic [REG_ADDR_BITS-1:0] OFS_STATUS = 32'h0000_0008;
   localparam logic [REG_ADDR_BITS-1:0] OFS_CONFIG = 32'h0000_000C;
   localparam logic [REG_ADDR_BITS-1:0] OFS_DEPTH = 32'h0000_0010;
   localparam logic [REG_ADDR_BITS-1:0] OFS_TICKS = 32'h0000_0014;
   localparam logic [REG_ADDR_BITS-1:0] OFS_BUF = 32'h0000_0020;
   // field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_WRITE_BIT = 1;
   localparam int CTRL_LEN_LSB = 8;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_ERR_BIT = 2;
   localparam int ST_EXOK_BIT = 3;
   localparam int ST_RESP_LSB = 4;
   // =====================================================
   // build option defaults
   localparam int DEF_REG_CLK_INDEP = 0;
   localparam int DEF_DATA_BITS = 32;
   localparam int DEF_BURST_CAP = 16;
   localparam int DEF_REALIGNER = 0;
   localparam int DEF_REDUCED = 0;
   localparam int DEF_RD_DEPTH = 4;
   localparam int DEF_WR_DEPTH = 4;
   localparam int DEF_BUF_FWD = 1;
   localparam int DEF_CHAIN = 0;
   localparam int DEF_TICK_CYCLES = 125;
   localparam int TICK_MAX = 1000000;
   localparam int DEPTH_MAX = 30;
   localparam int REDUCED_BURST_MAX = 64;
   // =====================================================
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [19:0] RST_TICK = 20'h0_0000;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_RADDR = 6'h02,
      S_RDATA = 6'h04,
      S_WADDR = 6'h08,
      S_WDATA = 6'h10,
      S_WRESP = 6'h20
   } cdpc_state_t;
endpackage

// File: cdpc_slave_model.sv
// behavioural descriptor memory slave facing the descriptor master port
`timescale 1ns/1ps
`default_nettype none
module cdpc_slave_model
   import cdpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [1:0] resp_code,
   input wire logic [31:0] araddr,
   input wire logic [7:0] arlen,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rlast,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] awlen,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wlast,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready
);
   int rn, ri, wn, wi, wfault;
   logic [31:0] a;
   logic [31:0] wmem [8];
   // =====================================
   // read channel: beat i returns base address plus i
   initial begin
      arready = 1'b0;
      rvalid = 1'b0;
      rlast = 1'b0;
      rdata = '0;
      rresp = '0;
      forever begin
         @(posedge clk);
         if (arvalid === 1'b1 && rst === 1'b0) begin
            rn = int'(arlen);
            a = araddr;
            if (slow) repeat (2) @(posedge clk);
            arready <= 1'b1;
            @(posedge clk);
            arready <= 1'b0;
            for (ri = 0; ri <= rn; ri++) begin
               if (slow) @(posedge clk);
               rvalid <= 1'b1;
               rdata <= a + 32'(ri);
               rresp <= resp_code;
               rlast <= (ri == rn);
               do @(posedge clk); while (rready !== 1'b1);
               // released data toggles so a stale sample never looks valid
               if (slow || ri == rn) begin
                  rvalid <= 1'b0;
                  rlast <= 1'b0;
                  rdata <= ~(a + 32'(ri));
               end
            end
         end
      end
   end
   // =====================================
   // write channel: stores beats, counts strobe and last faults
   initial begin
      awready = 1'b0;
      wready = 1'b0;
      bvalid = 1'b0;
      bresp = '0;
      wfault = 0;
      forever begin
         @(posedge clk);
         if (awvalid === 1'b1 && rst === 1'b0) begin
            wn = int'(awlen);
            awready <= 1'b1;
            @(posedge clk);
            awready <= 1'b0;
            wready <= 1'b1;
            for (wi = 0; wi <= wn; wi++) begin
               do @(posedge clk); while (wvalid !== 1'b1);
               wmem[wi % 8] = wdata;
               if (wstrb !== STRB_ALL || wlast !== (wi == wn)) wfault++;
            end
            wready <= 1'b0;
            if (slow) @(posedge clk);
            bvalid <= 1'b1;
            bresp <= resp_code;
            do @(posedge clk); while (bready !== 1'b1);
            bvalid <= 1'b0;
            bresp <= ~resp_code;
         end
      end
   end
endmodule
`default_nettype wire

// File: cdpc_top.sv
// descriptor master port with build options, register slave and delay tick timer
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - write bursts always use the four-byte beat size code
// - write burst type is incrementing only
// - write protection field held at all zeros
// - write cache field held at bufferable and modifiable
// - every write strobe lane asserted on descriptor writes
// - burst length field carries beats minus one
// - read response: okay success, slave or decode error failure, exclusive unsupported
// - write response decoded with the same meanings
// - write last only on the final beat of a burst
// - after reset valids and readies low, address length size data zero
// - register port is fixed at 32-bit address and data
// - option selects same or independent register port clock, default same
// - data-path width selectable 32, 64, 128, 256, default 32
// - data-path burst cap option 16 to 256, default 16
// - byte realigner only for 32 or 64 bit widths, default excluded
// - reduced mover limits width, realigner, bursts; ignored with chaining
// - read queue depth 1 to 30; outstanding is depth plus two, or two
// - write queue depth 1 to 30; outstanding is depth plus two, or two
// - store-and-forward option, included by default
// - descriptor chaining option, default excluded, port fixed at 32 bits
// - delay timer ticks every N clocks with chaining, idle without it, N 1 to one million, default 125
// - read bursts always use the four-byte beat size code
// - without chaining the port outputs are zero and inputs ignored
module cdpc_top
   import cdpc_pkg::*;
#(
   parameter int REGISTER_CLOCK_INDEPENDENT_OPT = DEF_REG_CLK_INDEP,
   parameter int DATA_PATH_BITS = DEF_DATA_BITS,
   parameter int TRANSFER_BURST_CAP = DEF_BURST_CAP,
   parameter int BYTE_REALIGNER_OPT = DEF_REALIGNER,
   parameter int REDUCED_MOVER_OPT = DEF_REDUCED,
   parameter int READ_QUEUE_DEPTH = DEF_RD_DEPTH,
   parameter int WRITE_QUEUE_DEPTH = DEF_WR_DEPTH,
   parameter int BUFFER_FORWARD_OPT = DEF_BUF_FWD,
   parameter int DESCRIPTOR_CHAIN_OPT = DEF_CHAIN,
   parameter int IRQ_DELAY_TICK_CYCLES = DEF_TICK_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [REG_ADDR_BITS-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [REG_WORD_BITS-1:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [REG_WORD_BITS-1:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic [DESC_PORT_ADDR_BITS-1:0] DESC_ARADDR,
   output logic [7:0] DESC_ARLEN,
   output logic [2:0] DESC_ARSIZE,
   output logic [1:0] DESC_ARBURST,
   output logic [2:0] DESC_ARPROT,
   output logic [3:0] DESC_ARCACHE,
   output logic DESC_ARVALID,
   input wire logic DESC_ARREADY,
   input wire logic [DESC_PORT_WORD_BITS-1:0] DESC_RDATA,
   input wire logic [1:0] DESC_RRESP,
   input wire logic DESC_RLAST,
   input wire logic DESC_RVALID,
   output logic DESC_RREADY,
   output logic [DESC_PORT_ADDR_BITS-1:0] DESC_AWADDR,
   output logic [7:0] DESC_AWLEN,
   output logic [2:0] DESC_AWSIZE,
   output logic [1:0] DESC_AWBURST,
   output logic [2:0] DESC_AWPROT,
   output logic [3:0] DESC_AWCACHE,
   output logic DESC_AWVALID,
   input wire logic DESC_AWREADY,
   output logic [DESC_PORT_WORD_BITS-1:0] DESC_WDATA,
   output logic [3:0] DESC_WSTRB,
   output logic DESC_WLAST,
   output logic DESC_WVALID,
   input wire logic DESC_WREADY,
   input wire logic [1:0] DESC_BRESP,
   input wire logic DESC_BVALID,
   output logic DESC_BREADY
);
   // =====================================================
   // build option decode
   localparam bit CHAIN_ON = (DESCRIPTOR_CHAIN_OPT == 1);
   localparam bit NARROW_PATH = (DATA_PATH_BITS == 32) || (DATA_PATH_BITS == 64);
   localparam bit WIDTH_OK = NARROW_PATH || (DATA_PATH_BITS == 128)
      || (DATA_PATH_BITS == 256);
   localparam bit BURST_OK = (TRANSFER_BURST_CAP == 16) || (TRANSFER_BURST_CAP == 32)
      || (TRANSFER_BURST_CAP == 64) || (TRANSFER_BURST_CAP == 128)
      || (TRANSFER_BURST_CAP == 256);
   // chaining overrides the reduced mover
   localparam bit REDUCED_ON = (REDUCED_MOVER_OPT == 1) && !CHAIN_ON;
   // reduced mover drops the realigner; otherwise only narrow paths keep it
   localparam bit REALIGNER_ON = (BYTE_REALIGNER_OPT == 1) && NARROW_PATH
      && !REDUCED_ON;
   localparam bit CONFIG_OK = WIDTH_OK && BURST_OK
      && !((BYTE_REALIGNER_OPT == 1) && !NARROW_PATH)
      && !(REDUCED_ON && (!NARROW_PATH || (TRANSFER_BURST_CAP > REDUCED_BURST_MAX)))
      && !((TRANSFER_BURST_CAP == 256) && (DATA_PATH_BITS == 256))
      && (READ_QUEUE_DEPTH >= 1) && (READ_QUEUE_DEPTH <= DEPTH_MAX)
      && (WRITE_QUEUE_DEPTH >= 1) && (WRITE_QUEUE_DEPTH <= DEPTH_MAX)
      && (IRQ_DELAY_TICK_CYCLES >= 1) && (IRQ_DELAY_TICK_CYCLES <= TICK_MAX)
      && (REGISTER_CLOCK_INDEPENDENT_OPT <= 1);
   localparam int RD_OUTSTANDING = (READ_QUEUE_DEPTH == 1) ? 2
      : READ_QUEUE_DEPTH + 2;
   localparam int WR_OUTSTANDING = (WRITE_QUEUE_DEPTH == 1) ? 2
      : WRITE_QUEUE_DEPTH + 2;
   localparam logic [19:0] TICK_LAST = 20'(IRQ_DELAY_TICK_CYCLES - 1);

   typedef struct packed {
      cdpc_state_t st;
      logic ack;
      logic [REG_WORD_BITS-1:0] rdata;
      logic [31:0] addr;
      logic [2:0] len;
      logic [2:0] beat;
      logic [DESC_WORDS-1:0][31:0] dbuf;
      logic [31:0] axaddr;
      logic [7:0] axlen;
      logic [2:0] axsize;
      logic [1:0] axburst;
      logic [31:0] wdata;
      logic done;
      logic err;
      logic exok;
      logic [1:0] resp;
      logic [19:0] tcnt;
      logic [31:0] ticks;
   } cdpc_regs_t;

   cdpc_regs_t r_q;
   cdpc_regs_t r_d;
   logic acc;
   logic wr_now;
   logic rd_hs;
   logic b_hs;
   logic [31:0] status_word;
   logic [31:0] config_word;
   logic [31:0] ctrl_word;

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // =====================================================
   // register slave: one wait state per access
   assign acc = AVS_READ || AVS_WRITE;
   assign AVS_WAITREQUEST = acc && !r_q.ack;
   assign AVS_READDATA = r_q.rdata;
   assign wr_now = AVS_WRITE && r_q.ack;
   assign rd_hs = DESC_RVALID && DESC_RREADY;
   assign b_hs = DESC_BVALID && DESC_BREADY;

   assign status_word = {24'h00_0000, 2'h0, r_q.resp, r_q.exok, r_q.err, r_q.done,
                         (r_q.st != S_IDLE)};
   assign config_word = {8'h00, 8'(TRANSFER_BURST_CAP - 1), 8'(DATA_PATH_BITS / 8), 2'h0,
                         CONFIG_OK, CHAIN_ON, (BUFFER_FORWARD_OPT == 1), REDUCED_ON,
                         REALIGNER_ON, (REGISTER_CLOCK_INDEPENDENT_OPT == 1)};
   assign ctrl_word = {21'h00_0000, r_q.len, 8'h00};

   always_comb begin
      r_d = r_q;
      r_d.ack = acc && !r_q.ack;
      if (acc && !r_q.ack && AVS_READ) begin
         unique case (AVS_ADDRESS)
            OFS_CTRL: r_d.rdata = ctrl_word;
            OFS_ADDR: r_d.rdata = r_q.addr;
            OFS_STATUS: r_d.rdata = status_word;
            OFS_CONFIG: r_d.rdata = config_word;
            OFS_DEPTH: r_d.rdata = {16'h0000, 8'(WR_OUTSTANDING), 8'(RD_OUTSTANDING)};
            OFS_TICKS: r_d.rdata = r_q.ticks;
            default: begin
               // unmapped reads return zero; buffer words decoded below
               r_d.rdata = RST_WORD;
               if (AVS_ADDRESS[31:5] == OFS_BUF[31:5] && AVS_ADDRESS[1:0] == 2'h0) begin
                  r_d.rdata = r_q.dbuf[AVS_ADDRESS[4:2]];
               end
            end
         endcase
      end
      // software side writes, applied at the edge that ends the cycle after the wait state
      if (wr_now) begin
         if (AVS_ADDRESS == OFS_ADDR && r_q.st == S_IDLE) begin
            r_d.addr = be_merge(r_q.addr, AVS_WRITEDATA, AVS_BYTEENABLE);
         end
         if (AVS_ADDRESS == OFS_STATUS && AVS_BYTEENABLE[0]) begin
            r_d.done = r_q.done && !AVS_WRITEDATA[ST_DONE_BIT];
            r_d.err = r_q.err && !AVS_WRITEDATA[ST_ERR_BIT];
            r_d.exok = r_q.exok && !AVS_WRITEDATA[ST_EXOK_BIT];
         end
         if (AVS_ADDRESS[31:5] == OFS_BUF[31:5] && AVS_ADDRESS[1:0] == 2'h0
             && r_q.st == S_IDLE) begin
            r_d.dbuf[AVS_ADDRESS[4:2]] = be_merge(r_q.dbuf[AVS_ADDRESS[4:2]],
                                                  AVS_WRITEDATA, AVS_BYTEENABLE);
         end
      end
      // =====================================================
      // descriptor transfer sequencer
      unique case (r_q.st)
         S_IDLE: begin
            // start ignored while busy or without chaining
            if (wr_now && AVS_ADDRESS == OFS_CTRL && AVS_BYTEENABLE[0]
                && AVS_BYTEENABLE[1] && AVS_WRITEDATA[CTRL_START_BIT] && CHAIN_ON) begin
               r_d.len = AVS_WRITEDATA[CTRL_LEN_LSB +: 3];
               r_d.beat = 3'h0;
               r_d.axaddr = r_q.addr;
               r_d.axlen = {5'h00, AVS_WRITEDATA[CTRL_LEN_LSB +: 3]};
               r_d.axsize = SIZE_4BYTE;
               r_d.axburst = BURST_INCR;
               r_d.st = AVS_WRITEDATA[CTRL_WRITE_BIT] ? S_WADDR : S_RADDR;
               r_d.wdata = r_q.dbuf[0];
            end
         end
         S_RADDR: begin
            if (DESC_ARREADY) begin
               r_d.st = S_RDATA;
            end
         end
         S_RDATA: begin
            if (rd_hs) begin
               r_d.dbuf[r_q.beat] = DESC_RDATA;
               r_d.beat = r_q.beat + 3'h1;
               r_d.resp = DESC_RRESP;
               // slave or decode error, bit 1 of the code
               if (DESC_RRESP[1]) begin
                  r_d.err = 1'b1;
               end
               if (DESC_RRESP == RESP_EXOKAY) begin
                  r_d.exok = 1'b1;
               end
               // burst ends on the slave's last beat
               if (DESC_RLAST) begin
                  r_d.st = S_IDLE;
                  r_d.done = 1'b1;
               end
            end
         end
         S_WADDR: begin
            if (DESC_AWREADY) begin
               r_d.st = S_WDATA;
            end
         end
         S_WDATA: begin
            if (DESC_WREADY) begin
               r_d.beat = r_q.beat + 3'h1;
               r_d.wdata = r_q.dbuf[r_q.beat + 3'h1];
               if (r_q.beat == r_q.len) begin
                  r_d.st = S_WRESP;
               end
            end
         end
         S_WRESP: begin
            if (b_hs) begin
               r_d.resp = DESC_BRESP;
               if (DESC_BRESP[1]) begin
                  r_d.err = 1'b1;
               end
               if (DESC_BRESP == RESP_EXOKAY) begin
                  r_d.exok = 1'b1;
               end
               r_d.st = S_IDLE;
               r_d.done = 1'b1;
            end
         end
      endcase
      // =====================================================
      // delay timer tick, idle when chaining is absent
      if (CHAIN_ON) begin
         if (r_q.tcnt >= TICK_LAST) begin
            r_d.tcnt = RST_TICK;
            r_d.ticks = r_q.ticks + 32'h0000_0001;
         end else begin
            r_d.tcnt = r_q.tcnt + 20'h0_0001;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         r_q <= '0;
         r_q.st <= S_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   // =====================================================
   // port drive; cache and strobe forced low without chaining, the rest held low by the idle state
   assign DESC_ARADDR = r_q.axaddr;
   assign DESC_ARLEN = r_q.axlen;
   assign DESC_ARSIZE = r_q.axsize;
   assign DESC_ARBURST = r_q.axburst;
   assign DESC_ARPROT = PROT_VALUE;
   assign DESC_ARCACHE = CHAIN_ON ? CACHE_VALUE : 4'h0;
   assign DESC_ARVALID = (r_q.st == S_RADDR);
   assign DESC_RREADY = (r_q.st == S_RDATA);
   assign DESC_AWADDR = r_q.axaddr;
   assign DESC_AWLEN = r_q.axlen;
   assign DESC_AWSIZE = r_q.axsize;
   assign DESC_AWBURST = r_q.axburst;
   assign DESC_AWPROT = PROT_VALUE;
   assign DESC_AWCACHE = CHAIN_ON ? CACHE_VALUE : 4'h0;
   assign DESC_AWVALID = (r_q.st == S_WADDR);
   assign DESC_WDATA = r_q.wdata;
   assign DESC_WSTRB = CHAIN_ON ? STRB_ALL : 4'h0;
   assign DESC_WVALID = (r_q.st == S_WDATA);
   assign DESC_WLAST = DESC_WVALID && (r_q.beat == r_q.len);
   assign DESC_BREADY = (r_q.st == S_WRESP);

   // =====================================================
   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   a_read_size: assert property (DESC_ARVALID |-> DESC_ARSIZE == SIZE_4BYTE)
      else $error("read size not four bytes");
   a_write_size: assert property (DESC_AWVALID |-> DESC_AWSIZE == SIZE_4BYTE)
      else $error("write size not four bytes");
   a_write_incr: assert property (DESC_AWVALID |-> DESC_AWBURST == BURST_INCR)
      else $error("write burst not incrementing");
   a_prot_cache: assert property (DESC_AWVALID |-> DESC_AWPROT == 3'h0
      && DESC_AWCACHE == 4'h3)
      else $error("write prot or cache wrong");
   a_strb_full: assert property (DESC_WVALID |-> DESC_WSTRB == 4'hF)
      else $error("write strobe not full");
   a_len_beats: assert property (DESC_WVALID && DESC_WREADY && DESC_WLAST
      |-> DESC_AWLEN == {5'h00, r_q.beat})
      else $error("beat count differs from length");
   a_wlast_end: assert property (DESC_WVALID && DESC_WREADY && DESC_WLAST
      |=> DESC_BREADY && !DESC_WVALID)
      else $error("burst continued after last");
   a_rerr_flag: assert property (rd_hs && DESC_RRESP[1] |=> r_q.err)
      else $error("read error not recorded");
   a_berr_flag: assert property (b_hs && DESC_BRESP[1] |=> r_q.err [*2])
      else $error("write error not recorded");
   a_reset_quiet: assert property ($fell(RST) |-> !DESC_ARVALID && !DESC_AWVALID
      && !DESC_WVALID && !DESC_RREADY && !DESC_BREADY && DESC_AWADDR == 32'h0
      && DESC_AWLEN == 8'h00 && DESC_ARSIZE == 3'h0 && DESC_WDATA == 32'h0)
      else $error("port not quiet after reset");
   a_unchained_low: assert property (!CHAIN_ON |-> DESC_ARVALID == 1'b0
      && DESC_AWVALID == 1'b0 && DESC_WSTRB == 4'h0 && DESC_ARCACHE == 4'h0)
      else $error("port active without chaining");
   a_tick_step: assert property (CHAIN_ON && r_q.tcnt == TICK_LAST
      |=> r_q.ticks == $past(r_q.ticks) + 32'h1 && r_q.tcnt == 20'h0)
      else $error("delay tick missed");
   a_wait_one: assert property (acc && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("register access waited too long");
   a_rlast_end: assert property (rd_hs && DESC_RLAST |=> !DESC_RREADY && r_q.done)
      else $error("read burst ran past last");
   a_rresp_kept: assert property (rd_hs && DESC_RLAST |=> r_q.resp == $past(DESC_RRESP))
      else $error("read response not recorded");
   a_bresp_kept: assert property (b_hs |=> r_q.done && r_q.resp == $past(DESC_BRESP))
      else $error("write response not recorded");

   c_read_done: cover property (rd_hs && DESC_RLAST && DESC_RRESP == RESP_OKAY);
   c_write_done: cover property (b_hs && DESC_BRESP == RESP_OKAY);
   c_error_seen: cover property (rd_hs && DESC_RRESP == RESP_DECERR);
   c_exok_seen: cover property (b_hs && DESC_BRESP == RESP_EXOKAY);
   c_multi_beat: cover property (DESC_WVALID && DESC_WREADY && DESC_WLAST
      && r_q.beat != 3'h0);
endmodule

`default_nettype wire

// File: central_dma_descriptor_port_config_test.sv
// self-checking bench for the descriptor master port block
`timescale 1ns/1ps
`default_nettype none
module central_dma_descriptor_port_config_test
   import cdpc_pkg::*;
;
   logic SYS_CLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, slow;
   logic [31:0] AVS_ADDRESS, AVS_WRITEDATA, AVS_READDATA, q, q2;
   logic [3:0] AVS_BYTEENABLE;
   logic [1:0] code;
   logic [31:0] ar_addr, aw_addr, r_data, w_data;
   logic [7:0] ar_len, aw_len;
   logic [2:0] ar_size, ar_prot, aw_size, aw_prot;
   logic [1:0] ar_burst, aw_burst, r_resp, b_resp;
   logic [3:0] ar_cache, aw_cache, w_strb;
   logic ar_valid, ar_ready, r_last, r_valid, r_ready, aw_valid, aw_ready;
   logic w_last, w_valid, w_ready, b_valid, b_ready;
   int error_cnt = 0, checked = 0, cycles = 0;

   cdpc_top #(.DESCRIPTOR_CHAIN_OPT(1), .IRQ_DELAY_TICK_CYCLES(4)) u_cdpc_top (
      .SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .DESC_ARADDR(ar_addr), .DESC_ARLEN(ar_len), .DESC_ARSIZE(ar_size),
      .DESC_ARBURST(ar_burst), .DESC_ARPROT(ar_prot), .DESC_ARCACHE(ar_cache),
      .DESC_ARVALID(ar_valid), .DESC_ARREADY(ar_ready), .DESC_RDATA(r_data),
      .DESC_RRESP(r_resp), .DESC_RLAST(r_last), .DESC_RVALID(r_valid), .DESC_RREADY(r_ready),
      .DESC_AWADDR(aw_addr), .DESC_AWLEN(aw_len), .DESC_AWSIZE(aw_size), .DESC_AWBURST(aw_burst),
      .DESC_AWPROT(aw_prot), .DESC_AWCACHE(aw_cache), .DESC_AWVALID(aw_valid),
      .DESC_AWREADY(aw_ready), .DESC_WDATA(w_data), .DESC_WSTRB(w_strb), .DESC_WLAST(w_last),
      .DESC_WVALID(w_valid), .DESC_WREADY(w_ready), .DESC_BRESP(b_resp),
      .DESC_BVALID(b_valid), .DESC_BREADY(b_ready));

   cdpc_slave_model u_cdpc_slave_model (
      .clk(SYS_CLK), .rst(RST), .slow(slow), .resp_code(code), .araddr(ar_addr),
      .arlen(ar_len), .arvalid(ar_valid), .arready(ar_ready), .rdata(r_data), .rresp(r_resp),
      .rlast(r_last), .rvalid(r_valid), .rready(r_ready), .awlen(aw_len), .awvalid(aw_valid),
      .awready(aw_ready), .wdata(w_data), .wstrb(w_strb), .wlast(w_last), .wvalid(w_valid),
      .wready(w_ready), .bresp(b_resp), .bvalid(b_valid), .bready(b_ready));

   initial begin
      SYS_CLK = 1'b0;
      forever #12.5 SYS_CLK = ~SYS_CLK;
   end
   // =====================================
   // bus tasks and checks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] r);
      AVS_ADDRESS <= a;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      do @(posedge SYS_CLK); while (AVS_WAITREQUEST !== 1'b0);
      r = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
      logic [31:0] r;
      acc(1'b1, a, d, be, r);
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] r);
      acc(1'b0, a, 32'h0, 4'hF, r);
   endtask
   task automatic wait_done(output logic [31:0] s);
      for (int k = 0; k < 100; k++) begin
         rd(OFS_STATUS, s);
         if (s[ST_DONE_BIT] === 1'b1) break;
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // a hung handshake ends here
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   // =====================================
   // scenarios
   initial begin
      RST = 1'b1;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_ADDRESS = '0;
      AVS_WRITEDATA = '0;
      AVS_BYTEENABLE = 4'h0;
      slow = 1'b0;
      code = RESP_OKAY;
      repeat (4) @(posedge SYS_CLK);
      RST <= 1'b0;
      @(posedge SYS_CLK);
      chk(32'({ar_valid, aw_valid, w_valid, r_ready, b_ready}), 32'h0, "idle");
      chk(32'({ar_size, ar_len, aw_size, aw_len}), 32'h0, "fields");
      chk(w_data, 32'h0, "wdata");
      rd(OFS_CONFIG, q);
      chk(q & 32'h00FF_FF3F, 32'h000F_0438, "config");
      rd(OFS_DEPTH, q);
      chk(q & 32'h0000_FFFF, 32'h0000_0606, "depth");
      for (int k = 0; k < 8; k++) wr(OFS_BUF + 32'(4 * k), 32'hA5A5_0000 + 32'(k));
      wr(OFS_ADDR, 32'h0000_1000);
      wr(OFS_CTRL, 32'h0000_0703);
      wait_done(q);
      chk(q & 32'h3F, 32'h02, "write status");
      for (int k = 0; k < 8; k++) begin
         chk(u_cdpc_slave_model.wmem[k], 32'hA5A5_0000 + 32'(k), "beat");
      end
      chk(32'(u_cdpc_slave_model.wfault), 32'h0, "strobe or last");
      chk(32'({aw_size, aw_burst, aw_prot, aw_cache, aw_len}),
          32'({SIZE_4BYTE, BURST_INCR, PROT_VALUE, CACHE_VALUE, 8'h07}), "aw");
      chk(aw_addr, 32'h0000_1000, "aw addr");
      wr(OFS_STATUS, 32'h0000_000E, 4'h1);
      // slow slave, three beats; word 3 must keep its old value
      slow <= 1'b1;
      wr(OFS_ADDR, 32'h0000_2000);
      wr(OFS_CTRL, 32'h0000_0201);
      wait_done(q);
      chk(q & 32'h3F, 32'h02, "read status");
      for (int k = 0; k < 4; k++) begin
         rd(OFS_BUF + 32'(4 * k), q);
         chk(q, (k < 3) ? 32'h0000_2000 + 32'(k) : 32'hA5A5_0003, "read word");
      end
      chk(32'({ar_size, ar_burst, ar_prot, ar_cache, ar_len}),
          32'({SIZE_4BYTE, BURST_INCR, PROT_VALUE, CACHE_VALUE, 8'h02}), "ar");
      wr(OFS_STATUS, 32'h0000_000E, 4'h1);
      slow <= 1'b0;
      // every non-okay code, both directions
      for (int c = 1; c < 4; c++) begin
         for (int d = 0; d < 2; d++) begin
            code <= 2'(c);
            wr(OFS_CTRL, (d == 1) ? 32'h0000_0003 : 32'h0000_0001);
            wait_done(q);
            q2 = 32'h02 | ((c >= 2) ? 32'h4 : 32'h8) | 32'(c << 4);
            chk(q & 32'h3F, q2, "resp");
            wr(OFS_STATUS, 32'h0000_000E, 4'h1);
            rd(OFS_STATUS, q);
            chk(q & 32'hF, 32'h0, "cleared");
         end
      end
      // both samples land 40 clocks apart
      rd(OFS_TICKS, q);
      repeat (37) @(posedge SYS_CLK);
      rd(OFS_TICKS, q2);
      chk(q2 - q, 32'd10, "ticks");
      conclude();
   end
endmodule
`default_nettype wire
